/* core/frt_axil_slave.sv */
// AXI4-Lite slave front end giving single-cycle register strobes
`timescale 1ns/1ns
module frt_axil_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write address and data
  input wire logic [frt_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [frt_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic wr_en,
  output logic [5:0] wr_idx,
  output logic [7:0] wr_byte,
  output logic rd_en,
  output logic [5:0] rd_idx,
  input wire logic [7:0] rd_byte
);
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] wdat_reg;
  logic wstrb0_reg;

  assign wr_byte = wdat_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_idx <= 6'h00;
      wdat_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      wr_en <= 1'b0;
      bvalid <= 1'b0;
      bresp <= frt_pkg::RESP_OKAY;
    end else begin
      wr_en <= 1'b0;
      if (!aw_held_reg && !bvalid && !awready) begin
        awready <= 1'b1;
      end
      if (!w_held_reg && !bvalid && !wready) begin
        wready <= 1'b1;
      end
      if (awvalid && awready) begin
        wr_idx <= awaddr[7:2];
        aw_held_reg <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wdat_reg <= wdata[7:0];
        wstrb0_reg <= wstrb[0];
        w_held_reg <= 1'b1;
        wready <= 1'b0;
      end
      if (aw_held_reg && w_held_reg && !bvalid) begin
        wr_en <= wstrb0_reg & frt_pkg::is_mapped(wr_idx);
        bresp <= frt_pkg::is_mapped(wr_idx) ? frt_pkg::RESP_OKAY : frt_pkg::RESP_SLVERR;
        bvalid <= 1'b1;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rd_idx <= 6'h00;
      rd_en <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= frt_pkg::RESP_OKAY;
    end else begin
      rd_en <= 1'b0;
      if (!rd_en && !rvalid && !arready) begin
        arready <= 1'b1;
      end
      if (arvalid && arready) begin
        rd_idx <= araddr[7:2];
        rd_en <= 1'b1;
        arready <= 1'b0;
      end
      // Data is taken in the strobe cycle so side effects match it
      if (rd_en) begin
        rdata <= {24'h00_0000, rd_byte};
        rresp <= frt_pkg::is_mapped(rd_idx) ? frt_pkg::RESP_OKAY : frt_pkg::RESP_SLVERR;
        rvalid <= 1'b1;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

/* core/frt_edge_detect.sv */
// Capture pin edge detector with selectable polarity
`timescale 1ns/1ns
module frt_edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and polarity
  input wire logic pin,
  input wire logic rising_sel,
  // Qualified edge
  output logic edge_pulse
);
  logic prev_reg;
  logic seen_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      prev_reg <= pin;
      seen_reg <= 1'b1;
    end
  end

  // No edge on the first sample after reset
  always_comb begin
    if (rising_sel) begin
      edge_pulse = seen_reg & pin & ~prev_reg;
    end else begin
      edge_pulse = seen_reg & ~pin & prev_reg;
    end
  end
endmodule

/* core/frt_timer.sv */
// Free-running timer with output compare, input capture and AXI4-Lite registers
// How it works
// - Sixteen-bit counter, one step per clock
// - Counter high-byte write presets to fff8
// - Wrap flag sets at counter all ones
// - Wrap flag clears: status read, count-high read
// - Compare match sets flag, copies level
// - Pin driven only when direction bit out
// - Compare-high write blocks matching one cycle
// - Reset loads compare register with ffff
// - Compare flag clears: status read, compare write
// - Qualified pin edge copies counter, always sensed
// - Edge select: zero falling, one rising
// - Capture always; blocked inside double read
// - Capture flag clears: status read, capture-high read
// - Status layout fixed; low five bits writable
// - Each flag requests interrupt when enabled
// - Counter feeds serial bit-rate source
// - Level bit reaches pin only via match
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module frt_timer (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // AXI4-Lite write address and data
  input wire logic [frt_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [frt_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Timer pins
  input wire logic CAPTURE_INPUT_PIN,
  input wire logic COMPARE_DIR_OUT,
  output logic COMPARE_OUTPUT_PIN_O,
  output logic COMPARE_OUTPUT_PIN_OE,
  // Interrupts
  output logic MASKABLE_IRQ_LINE,
  output logic EVENT_IRQ,
  // Serial bit-rate source
  output logic [15:0] BIT_RATE_COUNT
);
  logic wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_byte;
  logic rd_en;
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;
  logic cap_edge;

  logic [15:0] count_reg;
  logic [15:0] cmp_reg;
  logic [15:0] cap_reg;
  logic [4:0] ctrl_reg;
  logic wrap_flag_reg;
  logic cmp_flag_reg;
  logic cap_flag_reg;
  logic wrap_arm_reg;
  logic cmp_arm_reg;
  logic cap_arm_reg;
  logic cmp_hold_reg;
  logic cap_lock_reg;
  logic level_reg;
  logic pin_oe_reg;
  logic [2:0] evt_status_reg;
  logic [2:0] evt_mask_reg;
  logic irq_reg;
  logic evt_irq_reg;

  logic wr_ctrl;
  logic wr_count_hi;
  logic wr_cmp_hi;
  logic wr_cmp_lo;
  logic wr_evt_status;
  logic wr_evt_mask;
  logic rd_ctrl;
  logic rd_count_hi;
  logic rd_cap_hi;
  logic rd_cap_lo;
  logic wrap_hit;
  logic cmp_hit;
  logic wrap_flag_next;
  logic cmp_flag_next;
  logic cap_flag_next;
  logic [2:0] evt_now;
  logic [2:0] evt_status_next;
  logic [7:0] ctrl_view;

  // A new event wins over a clear sequence that completes in the same cycle
  function automatic logic flag_step(input logic hit, input logic flag, input logic arm, input logic take);
    flag_step = hit | (flag & ~(arm & take));
  endfunction

  frt_axil_slave u_bus (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_byte(wr_byte),
    .rd_en(rd_en),
    .rd_idx(rd_idx),
    .rd_byte(rd_byte)
  );

  // edge sensed on the pin regardless of direction
  frt_edge_detect u_edge (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .pin(CAPTURE_INPUT_PIN),
    .rising_sel(ctrl_reg[frt_pkg::BIT_EDGE_SEL]),
    .edge_pulse(cap_edge)
  );

  // Access decode
  assign wr_ctrl = wr_en && wr_idx == frt_pkg::IDX_CTRL_STATUS;
  assign wr_count_hi = wr_en && wr_idx == frt_pkg::IDX_COUNT_HI;
  assign wr_cmp_hi = wr_en && wr_idx == frt_pkg::IDX_CMP_HI;
  assign wr_cmp_lo = wr_en && wr_idx == frt_pkg::IDX_CMP_LO;
  assign wr_evt_status = wr_en && wr_idx == frt_pkg::IDX_EVT_STATUS;
  assign wr_evt_mask = wr_en && wr_idx == frt_pkg::IDX_EVT_MASK;
  assign rd_ctrl = rd_en && rd_idx == frt_pkg::IDX_CTRL_STATUS;
  assign rd_count_hi = rd_en && rd_idx == frt_pkg::IDX_COUNT_HI;
  assign rd_cap_hi = rd_en && rd_idx == frt_pkg::IDX_CAP_HI;
  assign rd_cap_lo = rd_en && rd_idx == frt_pkg::IDX_CAP_LO;

  assign wrap_hit = count_reg == frt_pkg::COUNT_ALL_ONES;
  // skip the cycle after a high-byte write
  assign cmp_hit = !cmp_hold_reg && count_reg == cmp_reg;

  // wrap flag clear sequence, set wins
  assign wrap_flag_next = flag_step(wrap_hit, wrap_flag_reg, wrap_arm_reg, rd_count_hi);
  // compare flag clear sequence, set wins
  assign cmp_flag_next = flag_step(cmp_hit, cmp_flag_reg, cmp_arm_reg, wr_cmp_hi | wr_cmp_lo);
  // capture flag clear sequence, set wins
  assign cap_flag_next = flag_step(cap_edge, cap_flag_reg, cap_arm_reg, rd_cap_hi);

  assign evt_now = {cap_edge, cmp_hit, wrap_hit};
  // Write-one-to-clear; a new event wins over the clear
  assign evt_status_next = evt_now | (evt_status_reg & ~(wr_evt_status ? wr_byte[2:0] : 3'h0));

  // bit order of the control/status view
  assign ctrl_view = {cap_flag_reg, cmp_flag_reg, wrap_flag_reg, ctrl_reg};

  always_comb begin
    case (rd_idx)
      frt_pkg::IDX_CTRL_STATUS: rd_byte = ctrl_view;
      frt_pkg::IDX_COUNT_HI: rd_byte = count_reg[15:8];
      frt_pkg::IDX_COUNT_LO: rd_byte = count_reg[7:0];
      frt_pkg::IDX_CMP_HI: rd_byte = cmp_reg[15:8];
      frt_pkg::IDX_CMP_LO: rd_byte = cmp_reg[7:0];
      frt_pkg::IDX_CAP_HI: rd_byte = cap_reg[15:8];
      frt_pkg::IDX_CAP_LO: rd_byte = cap_reg[7:0];
      frt_pkg::IDX_EVT_STATUS: rd_byte = {5'h00, evt_status_reg};
      frt_pkg::IDX_EVT_MASK: rd_byte = {5'h00, evt_mask_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  // Free-running counter
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      count_reg <= frt_pkg::COUNT_RESET;
    end else if (wr_count_hi) begin
      count_reg <= frt_pkg::COUNT_PRESET;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Compare register and its match hold-off
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cmp_reg <= frt_pkg::CMP_RESET;
      cmp_hold_reg <= 1'b0;
    end else begin
      // High byte lands alone, so the pair may be half new for a cycle
      // one-cycle match block
      cmp_hold_reg <= wr_cmp_hi;
      if (wr_cmp_hi) begin
        cmp_reg[15:8] <= wr_byte;
      end
      if (wr_cmp_lo) begin
        cmp_reg[7:0] <= wr_byte;
      end
    end
  end

  // Capture register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cap_reg <= frt_pkg::COUNT_RESET;
      cap_lock_reg <= 1'b0;
    end else begin
      // Keeps the low byte paired with the high byte already returned
      // lock between high and low byte reads
      if (rd_cap_hi) begin
        cap_lock_reg <= 1'b1;
      end else if (rd_cap_lo || rd_en || wr_en) begin
        cap_lock_reg <= 1'b0;
      end
      if (cap_edge && !cap_lock_reg) begin
        cap_reg <= count_reg;
      end
    end
  end

  // Control bits
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctrl_reg <= frt_pkg::CTRL_RESET[4:0];
    end else if (wr_ctrl) begin
      // only the low five bits take writes
      ctrl_reg <= wr_byte[4:0] & frt_pkg::CTRL_WR_MASK[4:0];
    end
  end

  // Event flags and their clear sequences
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wrap_flag_reg <= 1'b0;
      cmp_flag_reg <= 1'b0;
      cap_flag_reg <= 1'b0;
      wrap_arm_reg <= 1'b0;
      cmp_arm_reg <= 1'b0;
      cap_arm_reg <= 1'b0;
    end else begin
      wrap_flag_reg <= wrap_flag_next;
      cmp_flag_reg <= cmp_flag_next;
      cap_flag_reg <= cap_flag_next;
      // arm by status read, consume by count-high read
      if (rd_ctrl) begin
        wrap_arm_reg <= wrap_flag_reg;
      end else if (rd_count_hi) begin
        wrap_arm_reg <= 1'b0;
      end
      // arm by status read, consume by compare write
      if (rd_ctrl) begin
        cmp_arm_reg <= cmp_flag_reg;
      end else if (wr_cmp_hi || wr_cmp_lo) begin
        cmp_arm_reg <= 1'b0;
      end
      // arm by status read, consume by capture-high read
      if (rd_ctrl) begin
        cap_arm_reg <= cap_flag_reg;
      end else if (rd_cap_hi) begin
        cap_arm_reg <= 1'b0;
      end
    end
  end

  // Compare output pin
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      level_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      // level moves to the pin only on a match
      if (cmp_hit) begin
        level_reg <= ctrl_reg[frt_pkg::BIT_OUT_LEVEL];
      end
      pin_oe_reg <= COMPARE_DIR_OUT;
    end
  end

  // Sticky event status and mask
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      evt_status_reg <= frt_pkg::EVT_RESET;
      evt_mask_reg <= frt_pkg::EVT_RESET;
    end else begin
      evt_status_reg <= evt_status_next;
      if (wr_evt_mask) begin
        evt_mask_reg <= wr_byte[2:0];
      end
    end
  end

  // Interrupt lines
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      irq_reg <= 1'b0;
      evt_irq_reg <= 1'b0;
    end else begin
      // each flag gated by its own enable
      irq_reg <= (wrap_flag_next & ctrl_reg[frt_pkg::BIT_WRAP_EN]) |
                 (cmp_flag_next & ctrl_reg[frt_pkg::BIT_CMP_EN]) |
                 (cap_flag_next & ctrl_reg[frt_pkg::BIT_CAP_EN]);
      evt_irq_reg <= |(evt_status_next & evt_mask_reg);
    end
  end

  assign COMPARE_OUTPUT_PIN_O = level_reg;
  assign COMPARE_OUTPUT_PIN_OE = pin_oe_reg;
  assign MASKABLE_IRQ_LINE = irq_reg;
  assign EVENT_IRQ = evt_irq_reg;
  // counter drives the serial bit-rate source
  assign BIT_RATE_COUNT = count_reg;
endmodule

/* include/frt_pkg.sv */
// Shared constants for the free-running timer with capture and compare
package frt_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_CTRL_STATUS = 6'h08;
  localparam logic [5:0] IDX_COUNT_HI = 6'h09;
  localparam logic [5:0] IDX_COUNT_LO = 6'h0a;
  localparam logic [5:0] IDX_CMP_HI = 6'h0b;
  localparam logic [5:0] IDX_CMP_LO = 6'h0c;
  localparam logic [5:0] IDX_CAP_HI = 6'h0d;
  localparam logic [5:0] IDX_CAP_LO = 6'h0e;
  localparam logic [5:0] IDX_EVT_STATUS = 6'h18;
  localparam logic [5:0] IDX_EVT_MASK = 6'h19;
  // Control/status bit positions
  localparam int BIT_OUT_LEVEL = 0;
  localparam int BIT_EDGE_SEL = 1;
  localparam int BIT_WRAP_EN = 2;
  localparam int BIT_CMP_EN = 3;
  localparam int BIT_CAP_EN = 4;
  localparam int BIT_WRAP_FLAG = 5;
  localparam int BIT_CMP_FLAG = 6;
  localparam int BIT_CAP_FLAG = 7;
  localparam logic [7:0] CTRL_WR_MASK = 8'h1f;
  // Event status and mask bit positions
  localparam int EVT_WRAP = 0;
  localparam int EVT_CMP = 1;
  localparam int EVT_CAP = 2;
  // Reset and preset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_PRESET = 16'hfff8;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] CMP_RESET = 16'hffff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] EVT_RESET = 3'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // True for an index that holds a register
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx >= IDX_CTRL_STATUS && idx <= IDX_CAP_LO) ||
                idx == IDX_EVT_STATUS || idx == IDX_EVT_MASK;
  endfunction
endpackage

/* testbench/frt_pin_partner.sv */
// Signal source on the capture pin and pulled-up load on the compare pin
`timescale 1ns/1ns
module frt_pin_partner (
  // Clock
  input wire logic clk,
  // Capture source
  output logic cap_pin,
  // Compare load
  input wire logic cmp_o,
  input wire logic cmp_oe,
  output logic load_level
);
  // Undriven pin is pulled high at the load
  assign load_level = cmp_oe ? cmp_o : 1'b1;
  initial cap_pin = 1'b0;
  task automatic drive_level(input logic v);
    @(posedge clk);
    cap_pin <= v;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* testbench/frt_timer_checker.sv */
// Concurrent checks on the timer's top-level ports
`timescale 1ns/1ns
module frt_timer_checker (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Bus
  input wire logic [frt_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic [frt_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  // Timer
  input wire logic COMPARE_DIR_OUT,
  input wire logic COMPARE_OUTPUT_PIN_OE,
  input wire logic MASKABLE_IRQ_LINE,
  input wire logic [15:0] BIT_RATE_COUNT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence ar_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence r_answer;
    !S_AXI_ARREADY ##1 S_AXI_RVALID;
  endsequence
  sequence w_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence

  cnt_clear_a:
    assert property (disable iff (1'b0) !RST_N |=> BIT_RATE_COUNT == 16'h0000 && !MASKABLE_IRQ_LINE)
      else $error("count or irq not cleared by reset");
  cnt_step_a:
    assert property ($past(RST_N) |-> BIT_RATE_COUNT == $past(BIT_RATE_COUNT) + 16'h0001 ||
                     BIT_RATE_COUNT == 16'hfff8)
      else $error("counter neither stepped nor preset");
  oe_follow_a:
    assert property ($past(RST_N) |-> COMPARE_OUTPUT_PIN_OE == $past(COMPARE_DIR_OUT))
      else $error("pin enable does not follow direction bit");
  rd_answer_a:
    assert property (ar_taken |=> r_answer)
      else $error("read answer not two cycles after take");
  wr_answer_a:
    assert property (w_taken |-> ##2 S_AXI_BVALID)
      else $error("write response not two cycles after take");
  rd_upper_a:
    assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
  rd_unmapped_a:
    assert property (ar_taken and S_AXI_ARADDR[7:2] < 6'h08 |-> ##2 S_AXI_RRESP == 2'h2)
      else $error("unmapped read not refused");
  wr_unmapped_a:
    assert property (w_taken and S_AXI_AWADDR[7:2] < 6'h08 |-> ##2 S_AXI_BRESP == 2'h2)
      else $error("unmapped write not refused");
endmodule

bind frt_timer frt_timer_checker i_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .COMPARE_DIR_OUT(COMPARE_DIR_OUT), .COMPARE_OUTPUT_PIN_OE(COMPARE_OUTPUT_PIN_OE),
  .MASKABLE_IRQ_LINE(MASKABLE_IRQ_LINE), .BIT_RATE_COUNT(BIT_RATE_COUNT));

/* testbench/test_frt_timer.sv */
// Self-checking bench for the free-running timer
`timescale 1ns/1ns
module test_frt_timer;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, dir_out;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0] wstrb;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, cap_pin, pin_o, pin_oe, irq, evt_irq, load_level;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] count;
  int err_total, samples_checked, cycles;

  frt_timer i_dut (.CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CAPTURE_INPUT_PIN(cap_pin),
    .COMPARE_DIR_OUT(dir_out), .COMPARE_OUTPUT_PIN_O(pin_o), .COMPARE_OUTPUT_PIN_OE(pin_oe),
    .MASKABLE_IRQ_LINE(irq), .EVENT_IRQ(evt_irq), .BIT_RATE_COUNT(count));
  frt_pin_partner i_src (.clk(clk), .cap_pin(cap_pin), .cmp_o(pin_o), .cmp_oe(pin_oe), .load_level(load_level));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic [1:0] er = frt_pkg::RESP_OKAY);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    check("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] v, output logic [1:0] rr);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [5:0] idx, input logic [7:0] exp,
                      input logic [1:0] er = frt_pkg::RESP_OKAY);
    logic [31:0] v;
    logic [1:0] rr;
    rd(idx, v, rr);
    check(name, 32'(rr), 32'(er));
    if (er === frt_pkg::RESP_OKAY) check(name, v, {24'h0, exp});
  endtask

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, dir_out} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk("ctrl_rst", frt_pkg::IDX_CTRL_STATUS, 8'h00);
    rchk("cmp_hi_rst", frt_pkg::IDX_CMP_HI, 8'hff);
    rchk("cmp_lo_rst", frt_pkg::IDX_CMP_LO, 8'hff);
    wr(frt_pkg::IDX_CTRL_STATUS, 8'hff);
    rchk("ctrl_wr", frt_pkg::IDX_CTRL_STATUS, 8'h1f);
    wr(6'h00, 8'h01, frt_pkg::RESP_SLVERR);
    rchk("unmapped", 6'h00, 8'h00, frt_pkg::RESP_SLVERR);
    wr(frt_pkg::IDX_CTRL_STATUS, 8'h05);
    wr(frt_pkg::IDX_CMP_HI, 8'h01);
    wr(frt_pkg::IDX_CMP_LO, 8'h00);
    dir_out <= 1'b1;
    settle(2);
    check("load_sw", 32'(load_level), 32'h0);
    wr(frt_pkg::IDX_COUNT_HI, 8'h00);
    @(negedge clk);
    check("count_preset", 32'(count[15:4]), 32'hfff);
    settle(20);
    check("irq_wrap", 32'(irq), 32'h1);
    rd(frt_pkg::IDX_COUNT_HI, d, r);
    rchk("ctrl_wrap", frt_pkg::IDX_CTRL_STATUS, 8'h25);
    rd(frt_pkg::IDX_COUNT_HI, d, r);
    rchk("ctrl_wrap_clr", frt_pkg::IDX_CTRL_STATUS, 8'h05);
    settle(2);
    check("irq_clr", 32'(irq), 32'h0);
    // Counter passes the compare value during this wait
    settle(300);
    check("load_match", 32'(load_level), 32'h1);
    check("irq_masked", 32'(irq), 32'h0);
    rchk("ctrl_cmp", frt_pkg::IDX_CTRL_STATUS, 8'h45);
    wr(frt_pkg::IDX_CMP_LO, 8'h00);
    rchk("ctrl_cmp_clr", frt_pkg::IDX_CTRL_STATUS, 8'h05);
    dir_out <= 1'b0;
    settle(2);
    check("pin_oe_off", 32'(pin_oe), 32'h0);
    for (int s = 0; s < 2; s++) begin
      wr(frt_pkg::IDX_CTRL_STATUS, {6'h0, s[0], 1'b0});
      i_src.drive_level(1'b1);
      rchk("cap_rise", frt_pkg::IDX_CTRL_STATUS, {s[0], 5'h0, s[0], 1'b0});
      i_src.drive_level(1'b0);
      rchk("cap_fall", frt_pkg::IDX_CTRL_STATUS, {1'b1, 5'h0, s[0], 1'b0});
      rd(frt_pkg::IDX_CAP_HI, d, r);
      rchk("cap_clr", frt_pkg::IDX_CTRL_STATUS, {6'h0, s[0], 1'b0});
    end
    wr(frt_pkg::IDX_EVT_MASK, 8'h01);
    settle(2);
    check("evt_irq_on", 32'(evt_irq), 32'h1);
    rchk("evt_status", frt_pkg::IDX_EVT_STATUS, 8'h07);
    wr(frt_pkg::IDX_EVT_MASK, 8'h00);
    settle(2);
    check("evt_irq_mask", 32'(evt_irq), 32'h0);
    wr(frt_pkg::IDX_EVT_STATUS, 8'h07);
    rchk("evt_clr", frt_pkg::IDX_EVT_STATUS, 8'h00);
    // Preset gives a known count: compare hold-off, capture value and read lock
    wr(frt_pkg::IDX_CMP_HI, 8'h00);
    wr(frt_pkg::IDX_CMP_LO, 8'hfc);
    wr(frt_pkg::IDX_COUNT_HI, 8'h00);
    wr(frt_pkg::IDX_CMP_HI, 8'hff);
    i_src.drive_level(1'b1);
    rd(frt_pkg::IDX_CTRL_STATUS, d, r);
    check("cmp_hold", 32'(d[frt_pkg::BIT_CMP_FLAG]), 32'h0);
    rchk("cap_hi", frt_pkg::IDX_CAP_HI, 8'hff);
    i_src.drive_level(1'b0);
    i_src.drive_level(1'b1);
    rchk("cap_lo_lock", frt_pkg::IDX_CAP_LO, 8'hfd);
    wrap_up();
  end
endmodule
